// File: bench/cble_mem_model.sv
/*
  Far-side model: program memory, data memory and I/O space.
  Assumes the core reads all three combinationally in the strobe cycle.
*/
module cble_mem_model (
  input  wire logic        MCLK,     // Clock
  input  wire logic [15:0] PM_ADDR,  // Program address
  output logic      [15:0] PM_DATA,  // Program word
  input  wire logic [15:0] DM_ADDR,  // Data address
  input  wire logic        DM_RE,    // Data read
  output logic      [7:0]  DM_RDATA, // Data byte
  input  wire logic [4:0]  IO_ADDR,  // I/O address
  input  wire logic        IO_RE,    // I/O read
  output logic      [7:0]  IO_RDATA  // I/O byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] pm [0:255];
  logic [7:0]  dm [0:255];
  logic [7:0]  io [0:31];
  logic [7:0]  dm_q = 8'h00;
  logic [7:0]  io_q = 8'h00;
  assign PM_DATA = pm[PM_ADDR[7:0]];
  // Unread lines show the inverse of the last byte
  assign DM_RDATA = DM_RE ? dm[DM_ADDR[7:0]] : ~dm_q;
  assign IO_RDATA = IO_RE ? io[IO_ADDR] : ~io_q;
  always @(posedge MCLK) begin
    if (DM_RE) begin
      dm_q <= DM_RDATA;
    end
    if (IO_RE) begin
      io_q <= IO_RDATA;
    end
  end
endmodule

// File: bench/compare_branch_load_exec_tb.sv
/*
  Self-checking bench: a program model predicts PM/DM/IO strobes per cycle.
  Assumes the core and the memory model, zero-wait APB.
*/
module compare_branch_load_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic MCLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, DM_RE, IO_RE;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd_w;
  logic [15:0] PM_ADDR, PM_DATA, DM_ADDR;
  logic [7:0]  DM_RDATA, IO_RDATA;
  logic [4:0]  IO_ADDR;
  logic        err;
  int unsigned seed = 22;
  int mismatches = 0;
  int num_checks = 0;
  int r [0:31];
  int fl, pc, a, b, v;
  int e_pm [$];
  int e_dm [$];
  int e_io [$];

  cble_core cble_core_inst (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PM_ADDR(PM_ADDR), .PM_DATA(PM_DATA), .DM_ADDR(DM_ADDR),
    .DM_RE(DM_RE), .DM_RDATA(DM_RDATA), .IO_ADDR(IO_ADDR), .IO_RE(IO_RE),
    .IO_RDATA(IO_RDATA));
  cble_mem_model cble_mem_model_inst (.MCLK(MCLK), .PM_ADDR(PM_ADDR), .PM_DATA(PM_DATA),
    .DM_ADDR(DM_ADDR), .DM_RE(DM_RE), .DM_RDATA(DM_RDATA), .IO_ADDR(IO_ADDR),
    .IO_RE(IO_RE), .IO_RDATA(IO_RDATA));

  initial begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end

  function automatic int rnd(input int m);
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed % m);
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    num_checks++;
    if (got !== want) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    int n;
    @(posedge MCLK);
    PSEL    <= 1'b1;
    PWRITE  <= wr;
    PADDR   <= ad;
    PWDATA  <= wd;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      wrap_up();
    end
    rd_w = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic restart();
    RST_N <= 1'b0;
    repeat (2) @(posedge MCLK);
    RST_N <= 1'b1;
    for (int i = 0; i < 256; i++) cble_mem_model_inst.pm[i] = 16'h0000;
    pc = 0;
    fl = 0;
  endtask

  // Expected port state for one cycle; -1 or -2 means strobe low, address unchecked
  task automatic cyc(input int p, input int d, input int i);
    e_pm.push_back(p);
    e_dm.push_back(d);
    e_io.push_back(i);
  endtask

  task automatic put(input int w);
    cble_mem_model_inst.pm[pc] = w[15:0];
    pc++;
  endtask

  task automatic op1(input int w);
    cyc(pc, -1, -1);
    put(w);
  endtask

  task automatic load_constant_op(input int d, input int k);
    r[d] = k;
    op1(16'hE000 | ((k >> 4) << 8) | ((d - 16) << 4) | (k & 15));
  endtask

  task automatic mov(input int d, input int s, input int w);
    r[d] = r[s];
    if (w) r[d + 1] = r[s + 1];
    op1(w ? 16'h0100 | ((d >> 1) << 4) | (s >> 1)
          : 16'h2C00 | ((s >> 4) << 9) | (d << 4) | (s & 15));
  endtask

  // Compare: s < 0 takes immediate k, else register s with carry
  task automatic cmp(input int d, input int s, input int k);
    int c, x, res, sr, nf;
    c = s < 0 ? 0 : fl & 1;
    x = s < 0 ? k : r[s];
    res = r[d] - x - c;
    sr = (r[d] > 127 ? r[d] - 256 : r[d]) - (x > 127 ? x - 256 : x) - c;
    nf = fl & 8'hC0;
    nf[0] = res < 0;
    nf[1] = (res & 255) == 0 && (s < 0 || fl[1]);
    nf[2] = res[7];
    nf[3] = sr < -128 || sr > 127;
    nf[4] = nf[2] ^ nf[3];
    nf[5] = (r[d] & 15) - (x & 15) - c < 0;
    fl = nf;
    op1(s < 0 ? 16'h3000 | ((k >> 4) << 8) | ((d - 16) << 4) | (k & 15)
              : 16'h0400 | ((s >> 4) << 9) | (d << 4) | (s & 15));
  endtask

  task automatic br(input int s, input int set, input int k);
    int f;
    f = s == 4 ? fl[2] ^ fl[3] : fl[s];
    cyc(pc, -1, -1);
    if (f == set) cyc(pc + k + 1, -1, -1);
    put(16'hF000 | ((1 - set) << 10) | ((k & 127) << 3) | s);
    if (f == set) pc = pc + k;
  endtask

  task automatic load_absolute_op(input int d, input int k);
    cyc(pc, -1, -1);
    cyc(pc + 1, k, -1);
    r[d] = cble_mem_model_inst.dm[k & 255];
    put(16'h9000 | (d << 4));
    put(k);
  endtask

  // Mode 0 plain, 1 post-increment, 2 pre-decrement, 3 displacement q
  task automatic ld(input int d, input int p, input int m, input int q);
    int ad, bs;
    ad = r[p + 1] * 256 + r[p];
    bs = p == 26 ? 12 : (p == 28 ? 8 : 0);
    if (m == 2) ad = (ad + 65535) & 65535;
    cyc(pc, -1, -1);
    cyc(pc + 1, (ad + q) & 65535, -1);
    r[d] = cble_mem_model_inst.dm[(ad + q) & 255];
    if (m == 1) ad = (ad + 1) & 65535;
    r[p] = ad & 255;
    r[p + 1] = ad >> 8;
    if (m == 1 || m == 2 || p == 26) put(16'h9000 | (d << 4) | (bs + m));
    else put(16'h8000 | ((q >> 5) << 13) | (((q >> 3) & 3) << 10) | (d << 4) | (bs & 8) | (q & 7));
  endtask

  task automatic run(input string name);
    apb(1'b1, 12'h000, 32'h0000_0001);
    while (e_pm.size() > 0) begin
      #1;
      if (e_pm[0] >= 0) check(PM_ADDR, e_pm[0]);
      if (e_dm[0] >= 0) check(DM_ADDR, e_dm[0]);
      if (e_io[0] >= 0) check(IO_ADDR, e_io[0]);
      check(DM_RE, e_dm[0] >= 0);
      check(IO_RE, e_io[0] >= 0);
      void'(e_pm.pop_front());
      void'(e_dm.pop_front());
      void'(e_io.pop_front());
      @(posedge MCLK);
    end
    apb(1'b0, 12'h008, 32'h0);
    check(rd_w, fl);
    $display("test %s done", name);
  endtask

  initial begin
    {RST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    for (int i = 0; i < 256; i++) cble_mem_model_inst.dm[i] = rnd(256);
    repeat (10) @(posedge MCLK);
    RST_N <= 1'b1;
    // Reset state, unmapped access, flag write-back
    apb(1'b0, 12'h004, 32'h0);
    check(rd_w, 32'h0100_0000);
    apb(1'b0, 12'h00C, 32'h0);
    check({rd_w[30:0], err}, 32'h0000_0001);
    fl = rnd(256);
    apb(1'b1, 12'h008, fl);
    apb(1'b0, 12'h008, 32'h0);
    check(rd_w, fl);
    $display("test registers done");
    restart();
    for (int i = 16; i < 32; i++) load_constant_op(i, rnd(256));
    for (int i = 0; i < 6; i++) begin
      // Low registers have no reset value: write before comparing
      mov(i, 20 + i, 0);
      cmp(16 + i, -1, i[0] ? r[16 + i] : rnd(256));
      cmp(i, 17 + i, 0);
    end
    mov(26, 2, 1);
    ld(16, 26, 0, 0);
    run("compare and move");
    for (int j = 0; j < 32; j++) begin
      restart();
      fl = rnd(256);
      apb(1'b1, 12'h008, fl);
      repeat (30) op1(0);
      v = rnd(60) - 30;
      br(j & 7, (j >> 3) & 1, v >= -1 ? v + 2 : v);
      op1(0);
      run("branch");
    end
    for (int j = 0; j < 16; j++) begin
      restart();
      a = j[0] ? rnd(32) : 16 + rnd(16);
      b = rnd(8);
      v = rnd(256);
      v[b] = j[3] ? j[1] : !j[1];
      if (!j[0]) load_constant_op(a, v);
      cyc(pc, -1, j[0] ? a : -1);
      if (j[0]) cble_mem_model_inst.io[a] = v[7:0];
      put((j[0] ? 16'h9900 | (a << 3) : 16'hFC00 | (a << 4)) | (j[1] << 9) | b);
      if (j[3]) begin
        cyc(pc, -1, -1);
        if (j[2]) cyc(-2, -1, -1);
        put(j[2] ? 16'h9100 : 16'hE0F0);
        if (j[2]) put(16'h0040);
      end else if (j[2]) load_absolute_op(16, 64 + rnd(64));
      else load_constant_op(31, rnd(256));
      op1(0);
      run("skip");
    end
    restart();
    load_constant_op(26, 0);
    load_constant_op(28, 255);
    for (int i = 27; i < 32; i++) if (i != 28) load_constant_op(i, rnd(256));
    ld(16, 26, 2, 0);
    ld(17, 26, 1, 0);
    ld(18, 26, 0, 0);
    ld(19, 28, 1, 0);
    ld(20, 28, 2, 0);
    ld(21, 28, 3, rnd(64));
    ld(22, 30, 1, 0);
    ld(23, 30, 2, 0);
    ld(24, 30, 3, 63);
    ld(25, 28, 0, 0);
    load_absolute_op(17, rnd(65536));
    ld(16, 30, 0, 0);
    for (int i = 16; i < 26; i++) begin
      cmp(i, -1, r[i]);
      br(1, 1, 1);
    end
    run("load");
    wrap_up();
  end
endmodule

// File: src/cble_cfg.svh
/*
  Constants for the compare, branch and load execution block: opcode
  masks, status flag positions, pointer pairs and APB register offsets.
  Assumes it is included by bare name from the core file.
*/
`ifndef CBLE_CFG_SVH
`define CBLE_CFG_SVH

// Opcode mask and match pairs
`define CBLE_CPC_M   16'hFC00
`define CBLE_CPC_V   16'h0400
`define CBLE_CPI_M   16'hF000
`define CBLE_CPI_V   16'h3000
`define CBLE_MOV_M   16'hFC00
`define CBLE_MOV_V   16'h2C00
`define CBLE_COPY_REGISTER_WORD_OP_M  16'hFF00
`define CBLE_COPY_REGISTER_WORD_OP_V  16'h0100
`define CBLE_LDI_M   16'hF000
`define CBLE_LDI_V   16'hE000
`define CBLE_SBR_M   16'hFC08
`define CBLE_SBR_V   16'hFC00
`define CBLE_SBI_M   16'hFD00
`define CBLE_SBI_V   16'h9900
`define CBLE_BR_M    16'hF800
`define CBLE_BR_V    16'hF000
`define CBLE_LDP_M   16'hFE00
`define CBLE_LDP_V   16'h9000
`define CBLE_LDD_M   16'hD200
`define CBLE_LDD_V   16'h8000
`define CBLE_W2A_M   16'hFC0F
`define CBLE_W2A_V   16'h9000
`define CBLE_W2B_M   16'hFE0C
`define CBLE_W2B_V   16'h940C

// Pointer-mode nibbles of the indirect load group
`define CBLE_LD_X    4'hC
`define CBLE_LD_XP   4'hD
`define CBLE_LD_XM   4'hE
`define CBLE_LD_YP   4'h9
`define CBLE_LD_YM   4'hA
`define CBLE_LD_ZP   4'h1
`define CBLE_LD_ZM   4'h2
`define CBLE_LD_ABS  4'h0

// Pointer pair low registers
`define CBLE_RX      5'h1A
`define CBLE_RY      5'h1C
`define CBLE_RZ      5'h1E

// Flag positions in cpu_flags_register
`define CBLE_SR_C    0
`define CBLE_SR_Z    1
`define CBLE_SR_N    2
`define CBLE_SR_V    3
`define CBLE_SR_S    4
`define CBLE_SR_H    5
`define CBLE_SR_T    6
`define CBLE_SR_I    7

// APB map
`define CBLE_A_CTRL  12'h000
`define CBLE_A_STAT  12'h004
`define CBLE_A_FLAGS 12'h008
`define CBLE_CTRL_RUN 0
`define CBLE_PC_RST  16'h0000
`define CBLE_SR_RST  8'h00

`endif

// File: src/cble_cmp.sv
/*
  Subtract-and-flag unit for the compare instructions.
  Assumes operands settle within the cycle; it writes nothing itself.
*/
module cble_cmp (
  input  wire logic [7:0] a,        // Minuend
  input  wire logic [7:0] b,        // Subtrahend
  input  wire logic       cin,      // Carry flag in
  input  wire logic       zin,      // Zero flag in
  input  wire logic       use_c,    // Include carry
  output logic            c,        // Borrow out
  output logic            z,        // Zero
  output logic            n,        // Negative
  output logic            v,        // Overflow
  output logic            s,        // Sign
  output logic            h         // Half borrow
);
  logic [8:0] diff;
  logic [7:0] r;

  assign diff = {1'b0, a} - {1'b0, b} - {8'h00, use_c & cin};
  assign r    = diff[7:0];
  assign c    = diff[8];
  assign n    = r[7];
  assign h    = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
  assign v    = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
  assign s    = n ^ v;
  // With carry, zero only survives if it was already set
  assign z    = (r == 8'h00) & (~use_c | zin);
endmodule

// File: src/cble_core.sv
/*
  Execution core for compares, bit-test skips, flag branches, moves and
  data-memory loads, with an APB slave for run control and state.
  Assumes program, data and I/O memories answer combinationally in the
  same MCLK cycle as their address.
*/
`include "cble_cfg.svh"
module cble_core (
  input  wire logic        MCLK,     // System clock, 20 MHz
  input  wire logic        RST_N,    // Async reset, active low
  input  wire logic        PSEL,     // APB select
  input  wire logic        PENABLE,  // APB enable
  input  wire logic        PWRITE,   // APB write
  input  wire logic [11:0] PADDR,    // APB byte address
  input  wire logic [31:0] PWDATA,   // APB write data
  output logic      [31:0] PRDATA,   // APB read data
  output logic             PREADY,   // APB ready
  output logic             PSLVERR,  // APB error
  output logic      [15:0] PM_ADDR,  // Program word address
  input  wire logic [15:0] PM_DATA,  // Program word
  output logic      [15:0] DM_ADDR,  // Data memory address
  output logic             DM_RE,    // Data memory read
  input  wire logic [7:0]  DM_RDATA, // Data memory byte
  output logic      [4:0]  IO_ADDR,  // I/O address
  output logic             IO_RE,    // I/O read
  input  wire logic [7:0]  IO_RDATA  // I/O byte
);
  cble_pkg::cble_state_t state_q, state_d;
  logic [15:0] pc_q, pc_d;
  logic [7:0]  rf [32];
  logic [7:0]  cpu_flags_register_q, cpu_flags_register_d;
  logic        run_q;
  logic [31:0] prdata_q;
  logic [4:0]  ld_rd_q, ld_rd_d;
  logic        ld_abs_q, ld_abs_d;
  logic [15:0] ld_ea_q, ld_ea_d;
  logic [15:0] ins;
  logic        exec, wr_en, wr_pair, take, skip, two_word;
  logic [4:0]  wr_a, pb;
  logic [15:0] wr_v, ptr_v, br_tgt;
  logic        ld_post, ld_pre, ldp_hit;
  logic        is_cpc, is_cpi, is_mov, is_copy_register_word_op, is_ldi;
  logic        is_sbr, is_sbi, is_br, is_ldp, is_ldd;
  logic [7:0]  ca, cb;
  logic        cf_c, cf_z, cf_n, cf_v, cf_s, cf_h;
  logic        apb_wr, flags_wr;

  function automatic logic match(input logic [15:0] w, input logic [15:0] m,
                                 input logic [15:0] v);
    return (w & m) == v;
  endfunction

  // Branch flag select; the sign slot is evaluated as N xor V
  function automatic logic flag_sel(input logic [7:0] sr, input logic [2:0] s);
    if (s == 3'(`CBLE_SR_S)) begin
      return sr[`CBLE_SR_N] ^ sr[`CBLE_SR_V];
    end
    return sr[s];
  endfunction

  function automatic logic addr_hit(input logic [11:0] a);
    return a == `CBLE_A_CTRL || a == `CBLE_A_STAT || a == `CBLE_A_FLAGS;
  endfunction

  assign ins      = PM_DATA;
  assign PM_ADDR  = pc_q;
  assign exec     = run_q && state_q == cble_pkg::ST_EXEC;
  assign is_cpc   = match(ins, `CBLE_CPC_M, `CBLE_CPC_V);
  assign is_cpi   = match(ins, `CBLE_CPI_M, `CBLE_CPI_V);
  assign is_mov   = match(ins, `CBLE_MOV_M, `CBLE_MOV_V);
  assign is_copy_register_word_op  = match(ins, `CBLE_COPY_REGISTER_WORD_OP_M, `CBLE_COPY_REGISTER_WORD_OP_V);
  assign is_ldi   = match(ins, `CBLE_LDI_M, `CBLE_LDI_V);
  assign is_sbr   = match(ins, `CBLE_SBR_M, `CBLE_SBR_V);
  assign is_sbi   = match(ins, `CBLE_SBI_M, `CBLE_SBI_V);
  assign is_br    = match(ins, `CBLE_BR_M, `CBLE_BR_V);
  assign is_ldp   = match(ins, `CBLE_LDP_M, `CBLE_LDP_V);
  assign is_ldd   = match(ins, `CBLE_LDD_M, `CBLE_LDD_V);
  assign two_word = match(ins, `CBLE_W2A_M, `CBLE_W2A_V) ||
                    match(ins, `CBLE_W2B_M, `CBLE_W2B_V);
  assign br_tgt   = pc_q + {{9{ins[9]}}, ins[9:3]} + 16'h0001;
  assign take     = flag_sel(cpu_flags_register_q, ins[2:0]) != ins[10];
  assign IO_ADDR  = ins[7:3];
  assign IO_RE    = exec && is_sbi;
  assign ca       = is_cpi ? rf[{1'b1, ins[7:4]}] : rf[ins[8:4]];
  assign cb       = is_cpi ? {ins[11:8], ins[3:0]} : rf[{ins[9], ins[3:0]}];

  cble_cmp u_cmp (
    .a     (ca),
    .b     (cb),
    .cin   (cpu_flags_register_q[`CBLE_SR_C]),
    .zin   (cpu_flags_register_q[`CBLE_SR_Z]),
    .use_c (is_cpc),
    .c     (cf_c),
    .z     (cf_z),
    .n     (cf_n),
    .v     (cf_v),
    .s     (cf_s),
    .h     (cf_h)
  );

  // Pointer pair and mode of indirect loads
  always_comb begin
    pb      = `CBLE_RZ;
    ld_post = 1'b0;
    ld_pre  = 1'b0;
    ldp_hit = 1'b1;
    if (is_ldd) begin
      pb = ins[3] ? `CBLE_RY : `CBLE_RZ;
    end else begin
      unique case (ins[3:0])
        `CBLE_LD_X:   pb = `CBLE_RX;
        `CBLE_LD_XP:  begin pb = `CBLE_RX; ld_post = 1'b1; end
        `CBLE_LD_XM:  begin pb = `CBLE_RX; ld_pre = 1'b1; end
        `CBLE_LD_YP:  begin pb = `CBLE_RY; ld_post = 1'b1; end
        `CBLE_LD_YM:  begin pb = `CBLE_RY; ld_pre = 1'b1; end
        `CBLE_LD_ZP:  ld_post = 1'b1;
        `CBLE_LD_ZM:  ld_pre = 1'b1;
        `CBLE_LD_ABS: ldp_hit = 1'b1;
        default:      ldp_hit = 1'b0;
      endcase
    end
  end

  assign ptr_v = {rf[{pb[4:1], 1'b1}], rf[pb]};

  // Instruction sequencing
  always_comb begin
    state_d  = state_q;
    pc_d     = pc_q;
    cpu_flags_register_d   = cpu_flags_register_q;
    wr_en    = 1'b0;
    wr_pair  = 1'b0;
    wr_a     = ins[8:4];
    wr_v     = 16'h0000;
    ld_rd_d  = ld_rd_q;
    ld_abs_d = ld_abs_q;
    ld_ea_d  = ld_ea_q;
    skip     = 1'b0;
    DM_RE    = 1'b0;
    DM_ADDR  = ld_ea_q;
    unique case (state_q)
      cble_pkg::ST_EXEC: if (run_q) begin
        pc_d = pc_q + 16'h0001;
        if (is_cpc || is_cpi) begin
          cpu_flags_register_d[`CBLE_SR_C] = cf_c;
          cpu_flags_register_d[`CBLE_SR_Z] = cf_z;
          cpu_flags_register_d[`CBLE_SR_N] = cf_n;
          cpu_flags_register_d[`CBLE_SR_V] = cf_v;
          cpu_flags_register_d[`CBLE_SR_S] = cf_s;
          cpu_flags_register_d[`CBLE_SR_H] = cf_h;
        end else if (is_mov) begin
          wr_en = 1'b1;
          wr_v  = {8'h00, rf[{ins[9], ins[3:0]}]};
        end else if (is_copy_register_word_op) begin
          wr_en   = 1'b1;
          wr_pair = 1'b1;
          wr_a    = {ins[7:4], 1'b0};
          wr_v    = {rf[{ins[3:0], 1'b1}], rf[{ins[3:0], 1'b0}]};
        end else if (is_ldi) begin
          wr_en = 1'b1;
          wr_a  = {1'b1, ins[7:4]};
          wr_v  = {8'h00, ins[11:8], ins[3:0]};
        end else if (is_sbr || is_sbi) begin
          skip = is_sbr ? rf[ins[8:4]][ins[2:0]] == ins[9]
                        : IO_RDATA[ins[2:0]] == ins[9];
          if (skip) begin
            state_d = cble_pkg::ST_SKIP;
          end
        end else if (is_br) begin
          if (take) begin
            pc_d    = br_tgt;
            state_d = cble_pkg::ST_BUBBLE;
          end
        end else if (is_ldd || (is_ldp && ldp_hit)) begin
          state_d  = cble_pkg::ST_LOAD;
          ld_rd_d  = ins[8:4];
          ld_abs_d = is_ldp && ins[3:0] == `CBLE_LD_ABS;
          if (is_ldd) begin
            ld_ea_d = ptr_v + {10'h000, ins[13], ins[11:10], ins[2:0]};
          end else if (ld_pre) begin
            ld_ea_d = ptr_v - 16'h0001;
          end else begin
            ld_ea_d = ptr_v;
          end
          if (!is_ldd && (ld_pre || ld_post)) begin
            wr_en   = 1'b1;
            wr_pair = 1'b1;
            wr_a    = pb;
            wr_v    = ld_pre ? ptr_v - 16'h0001 : ptr_v + 16'h0001;
          end
        end
      end
      cble_pkg::ST_LOAD: begin
        DM_RE   = 1'b1;
        state_d = cble_pkg::ST_EXEC;
        if (ld_abs_q) begin
          DM_ADDR = PM_DATA;
          pc_d    = pc_q + 16'h0001;
        end
        wr_en = 1'b1;
        wr_a  = ld_rd_q;
        wr_v  = {8'h00, DM_RDATA};
      end
      cble_pkg::ST_SKIP: begin
        pc_d    = pc_q + 16'h0001;
        state_d = two_word ? cble_pkg::ST_SKIP2 : cble_pkg::ST_EXEC;
      end
      cble_pkg::ST_SKIP2: begin
        pc_d    = pc_q + 16'h0001;
        state_d = cble_pkg::ST_EXEC;
      end
      cble_pkg::ST_BUBBLE: state_d = cble_pkg::ST_EXEC;
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= cble_pkg::ST_EXEC;
      pc_q    <= `CBLE_PC_RST;
    end else begin
      state_q <= state_d;
      pc_q    <= pc_d;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ld_rd_q  <= 5'h00;
      ld_abs_q <= 1'b0;
      ld_ea_q  <= 16'h0000;
    end else begin
      ld_rd_q  <= ld_rd_d;
      ld_abs_q <= ld_abs_d;
      ld_ea_q  <= ld_ea_d;
    end
  end

  // Register file has no reset
  always_ff @(posedge MCLK) begin
    if (wr_en) begin
      rf[wr_a] <= wr_v[7:0];
      if (wr_pair) begin
        rf[{wr_a[4:1], 1'b1}] <= wr_v[15:8];
      end
    end
  end

  // APB slave, zero wait states
  assign PREADY   = 1'b1;
  assign PSLVERR  = PSEL && PENABLE && !addr_hit(PADDR);
  assign PRDATA   = prdata_q;
  assign apb_wr   = PSEL && PENABLE && PWRITE;
  assign flags_wr = apb_wr && PADDR == `CBLE_A_FLAGS;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      prdata_q <= 32'h00000000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      unique case (PADDR)
        `CBLE_A_CTRL:  prdata_q <= {31'h00000000, run_q};
        `CBLE_A_STAT:  prdata_q <= {3'h0, state_q, cpu_flags_register_q, pc_q};
        `CBLE_A_FLAGS: prdata_q <= {24'h000000, cpu_flags_register_q};
        default:       prdata_q <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      run_q <= 1'b0;
    end else if (apb_wr && PADDR == `CBLE_A_CTRL) begin
      run_q <= PWDATA[`CBLE_CTRL_RUN];
    end
  end

  // A core flag update that changes the flags wins over a software write in the same cycle
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      cpu_flags_register_q <= `CBLE_SR_RST;
    end else if (cpu_flags_register_d != cpu_flags_register_q) begin
      cpu_flags_register_q <= cpu_flags_register_d;
    end else if (flags_wr) begin
      cpu_flags_register_q <= PWDATA[7:0];
    end
  end

  property p_cmp;
    @(posedge MCLK) disable iff (!RST_N)
    (exec && (is_cpc || is_cpi)) |-> !wr_en ##1 cpu_flags_register_q[`CBLE_SR_C] == $past(cf_c);
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare wrote a register");

  property p_sbr_noskip;
    @(posedge MCLK) disable iff (!RST_N)
    (exec && is_sbr && !skip) |=> state_q == cble_pkg::ST_EXEC
      && pc_q == $past(pc_q) + 16'h0001;
  endproperty
  a_sbr_noskip: assert property (p_sbr_noskip) else $error("bad untaken skip");

  property p_sbi_skip;
    @(posedge MCLK) disable iff (!RST_N)
    (exec && is_sbi && skip) |=> state_q == cble_pkg::ST_SKIP
      ##1 (state_q == cble_pkg::ST_SKIP2 || pc_q == $past(pc_q, 2) + 16'h0002);
  endproperty
  a_sbi_skip: assert property (p_sbi_skip) else $error("bad io skip");

  property p_br_taken;
    @(posedge MCLK) disable iff (!RST_N)
    (exec && is_br && take) |=> pc_q == $past(br_tgt)
      && state_q == cble_pkg::ST_BUBBLE ##1 state_q == cble_pkg::ST_EXEC && $stable(pc_q);
  endproperty
  a_br_taken: assert property (p_br_taken) else $error("bad taken branch");

  property p_br_signed;
    @(posedge MCLK) disable iff (!RST_N)
    (exec && is_br && ins[2:0] == 3'(`CBLE_SR_S))
      |=> (state_q == cble_pkg::ST_BUBBLE)
        == (($past(cpu_flags_register_q[`CBLE_SR_N]) ^ $past(cpu_flags_register_q[`CBLE_SR_V])) != $past(ins[10]));
  endproperty
  a_br_signed: assert property (p_br_signed) else $error("bad signed branch");

  property p_post;
    @(posedge MCLK) disable iff (!RST_N)
    (exec && is_ldp && ldp_hit && ld_post) |-> wr_pair && wr_v == ptr_v + 16'h0001
      ##1 DM_RE && DM_ADDR == $past(ptr_v);
  endproperty
  a_post: assert property (p_post) else $error("bad post-increment load");

  property p_pre;
    @(posedge MCLK) disable iff (!RST_N)
    (exec && is_ldp && ld_pre) |=> DM_ADDR == $past(ptr_v) - 16'h0001;
  endproperty
  a_pre: assert property (p_pre) else $error("bad pre-decrement load");

  property p_disp;
    @(posedge MCLK) disable iff (!RST_N)
    (exec && is_ldd) |-> !wr_en ##1 state_q == cble_pkg::ST_LOAD ##1 state_q == cble_pkg::ST_EXEC;
  endproperty
  a_disp: assert property (p_disp) else $error("bad displacement load");

  property p_abs;
    @(posedge MCLK) disable iff (!RST_N)
    (state_q == cble_pkg::ST_LOAD && ld_abs_q) |-> DM_ADDR == PM_DATA
      ##1 rf[$past(ld_rd_q)] == $past(DM_RDATA);
  endproperty
  a_abs: assert property (p_abs) else $error("bad absolute load");

  property p_move;
    @(posedge MCLK) disable iff (!RST_N)
    (exec && (is_mov || is_copy_register_word_op || is_ldi) && !flags_wr)
      |=> $stable(cpu_flags_register_q) && state_q == cble_pkg::ST_EXEC;
  endproperty
  a_move: assert property (p_move) else $error("move changed flags");
endmodule

// File: src/cble_pkg.sv
/*
  Types for the compare, branch and load execution block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cble_pkg;
  typedef enum logic [4:0] {
    ST_EXEC   = 5'h01,
    ST_LOAD   = 5'h02,
    ST_SKIP   = 5'h04,
    ST_SKIP2  = 5'h08,
    ST_BUBBLE = 5'h10
  } cble_state_t;
endpackage
